// ==== rtl/fpgio_pin_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpgio_pin_filter
  import fpgio_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  // three-stage chain; only stage2 reads stage1
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stage1 <= 1'h0;
      stage2 <= 1'h0;
      stage3 <= 1'h0;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a new level once the two late stages agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      level_o <= 1'h0;
    end else if (stage2 == stage3) begin
      level_o <= stage3;
    end
  end

endmodule : fpgio_pin_filter
`default_nettype wire

// ==== rtl/fpgio_pkg.sv ====
// Overview of operation
// - a pin with both drive-high and drive-low requests set is driven low
// - level requests have no effect on an input pin, which stays undriven
// - writing one to level bits 7..4 requests high on pins 3..0; zeros ignored
// - writing one to level bits 3..0 requests low on pins 3..0; zeros ignored
// - writing one to direction bits 7..4 makes pins 3..0 outputs; zeros ignored
// - writing one to direction bits 3..0 makes pins 3..0 inputs; zeros ignored
// - a pin with both output and input direction bits set is an input
// - after reset all pins are inputs and the direction register reads zero
// - input register bits 7..4 return sampled levels of pins 3..0, any direction
// - input register low nibble reads zero and ignores writes
// - level request register at index 65h, read/write, resets to zero
// - direction register at index 66h, read/write, resets to zero
// - with forwarding gate bit 5 set, pin 3 high blocks forwarding
package fpgio_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int PIN_N  = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHIP_CTRL = 8'h40;
  localparam logic [7:0] IDX_LEVEL     = 8'h65;
  localparam logic [7:0] IDX_DIR       = 8'h66;
  localparam logic [7:0] IDX_SAMPLE    = 8'h67;

  localparam logic [ADDR_W-1:0] ADDR_CHIP_CTRL = {2'h0, IDX_CHIP_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LEVEL     = {2'h0, IDX_LEVEL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIR       = {2'h0, IDX_DIR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE    = {2'h0, IDX_SAMPLE, 2'h0};

  // field positions
  localparam int HIGH_LSB     = 4;
  localparam int LOW_LSB      = 0;
  localparam int SAMPLE_LSB   = 4;
  localparam int FWD_GATE_BIT = 5;
  localparam int GATE_PIN     = 3;

  // values after reset
  localparam logic [7:0] LEVEL_RST     = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'h00;
  localparam logic       FWD_GATE_RST  = 1'h0;
  localparam logic [3:0] SAMPLE_LO_VAL = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // write channel states, gray along idle -> one half -> response
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_ADDR = 2'h1,
    WR_RESP = 2'h3,
    WR_DATA = 2'h2
  } fpgio_wr_state_t;

  // read channel states
  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_RESP = 1'h1
  } fpgio_rd_state_t;

endpackage : fpgio_pkg

// ==== rtl/fpgio_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpgio_port
  import fpgio_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              reset_i,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [STRB_W-1:0] s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  // axi4-lite read data
  output logic [DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // general pins, split into input, output and enable
  input  wire logic [PIN_N-1:0]  general_pin_i,
  output logic [PIN_N-1:0]       general_pin_o,
  output logic [PIN_N-1:0]       general_pin_oe_o,
  // forwarding gate toward the bridge core
  output logic                   forward_block_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  fpgio_wr_state_t   wr_state;
  fpgio_wr_state_t   next_wr_state;
  fpgio_rd_state_t   rd_state;
  fpgio_rd_state_t   next_rd_state;

  logic [ADDR_W-1:0] held_waddr;
  logic [DATA_W-1:0] held_wdata;
  logic [STRB_W-1:0] held_wstrb;
  logic [1:0]        bresp;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        rresp;

  logic [7:0]        level_req;
  logic [7:0]        dir_req;
  logic              fwd_gate_en;
  logic [PIN_N-1:0]  pin_level;

  logic [PIN_N-1:0]  pin_out;
  logic [PIN_N-1:0]  pin_oe;
  logic              fwd_block;

  // ---------------------------------------------------------------
  // write channel handshakes
  // ---------------------------------------------------------------
  wire aw_fire  = s_axi_awvalid_i & s_axi_awready_o;
  wire w_fire   = s_axi_wvalid_i & s_axi_wready_o;
  wire b_fire   = s_axi_bvalid_o & s_axi_bready_i;
  wire have_aw  = aw_fire | (wr_state == WR_ADDR);
  wire have_w   = w_fire | (wr_state == WR_DATA);
  wire do_write = have_aw & have_w;

  // a half taken alone is parked until its partner arrives, so the master
  // may offer address and data together or apart without losing a beat
  // either half is taken in any order; both wait while a response stands
  assign s_axi_awready_o = (wr_state == WR_IDLE) | (wr_state == WR_DATA);
  assign s_axi_wready_o  = (wr_state == WR_IDLE) | (wr_state == WR_ADDR);
  assign s_axi_bvalid_o  = (wr_state == WR_RESP);
  assign s_axi_bresp_o   = bresp;

  // the write seen this cycle, from the live channel or the held half
  wire [ADDR_W-1:0] wr_addr = (wr_state == WR_ADDR) ? held_waddr : s_axi_awaddr_i;
  wire [DATA_W-1:0] wr_data = (wr_state == WR_DATA) ? held_wdata : s_axi_wdata_i;
  wire [STRB_W-1:0] wr_strb = (wr_state == WR_DATA) ? held_wstrb : s_axi_wstrb_i;

  // ---------------------------------------------------------------
  // write address decode, word aligned, low two bits ignored
  // ---------------------------------------------------------------
  wire [ADDR_W-3:0] wr_word     = wr_addr[ADDR_W-1:2];
  wire              wr_hit_chip = (wr_word == ADDR_CHIP_CTRL[ADDR_W-1:2]);
  wire              wr_hit_lvl  = (wr_word == ADDR_LEVEL[ADDR_W-1:2]);
  wire              wr_hit_dir  = (wr_word == ADDR_DIR[ADDR_W-1:2]);
  wire              wr_hit_smp  = (wr_word == ADDR_SAMPLE[ADDR_W-1:2]);
  wire              wr_mapped   = wr_hit_chip | wr_hit_lvl | wr_hit_dir | wr_hit_smp;
  wire              wr_lane0    = wr_strb[0];
  wire [7:0]        wr_byte     = wr_data[7:0];

  // only byte lane 0 carries a register; the other lanes are taken and dropped,
  // and a write with lane 0 disabled is answered but stores nothing
  // register write enables; the sample register takes no write
  wire wen_chip = do_write & wr_hit_chip & wr_lane0;
  wire wen_lvl  = do_write & wr_hit_lvl & wr_lane0;
  wire wen_dir  = do_write & wr_hit_dir & wr_lane0;

  // level and direction: ones accumulate, zeros leave the stored bits alone; the gate bit takes written bit 5
  wire [7:0] next_level_req = wen_lvl ? (level_req | wr_byte) : level_req;
  wire [7:0] next_dir_req   = wen_dir ? (dir_req | wr_byte) : dir_req;
  wire       next_fwd_gate  = wen_chip ? wr_byte[FWD_GATE_BIT] : fwd_gate_en;

  // the response state blocks both halves, so at most one write is under way
  // write state sequencing
  always_comb begin
    next_wr_state = wr_state;
    unique case (wr_state)
      WR_IDLE: begin
        if (aw_fire & w_fire) begin
          next_wr_state = WR_RESP;
        end else if (aw_fire) begin
          next_wr_state = WR_ADDR;
        end else if (w_fire) begin
          next_wr_state = WR_DATA;
        end
      end
      WR_ADDR: begin
        if (w_fire) begin
          next_wr_state = WR_RESP;
        end
      end
      WR_DATA: begin
        if (aw_fire) begin
          next_wr_state = WR_RESP;
        end
      end
      WR_RESP: begin
        if (b_fire) begin
          next_wr_state = WR_IDLE;
        end
      end
    endcase
  end

  // write state register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wr_state <= WR_IDLE;
    end else begin
      wr_state <= next_wr_state;
    end
  end

  // hold whichever half arrives first
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      held_waddr <= '0;
      held_wdata <= '0;
      held_wstrb <= '0;
    end else begin
      if (aw_fire) begin
        held_waddr <= s_axi_awaddr_i;
      end
      if (w_fire) begin
        held_wdata <= s_axi_wdata_i;
        held_wstrb <= s_axi_wstrb_i;
      end
    end
  end

  // an unmapped address is answered with an error and stores nothing
  // response code, fixed when both halves are in
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bresp <= RESP_OKAY;
    end else if (do_write) begin
      bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // requests are sticky: a written zero leaves a bit alone, so a stored one
  // clears only on reset; software cannot undo a low or input request
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      level_req   <= LEVEL_RST;
      dir_req     <= DIR_RST;
      fwd_gate_en <= FWD_GATE_RST;
    end else begin
      level_req   <= next_level_req;
      dir_req     <= next_dir_req;
      fwd_gate_en <= next_fwd_gate;
    end
  end

  // ---------------------------------------------------------------
  // pin input filtering, one filter per pin
  // ---------------------------------------------------------------
  // the filtered levels feed both the sample register and the forwarding
  // gate, so a glitch shorter than one clock reaches neither of them
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    fpgio_pin_filter u_filter (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .pin_i     (general_pin_i[p]),
      .level_o   (pin_level[p])
    );
  end

  // ---------------------------------------------------------------
  // pin drive resolution
  // ---------------------------------------------------------------
  wire [PIN_N-1:0] want_high = level_req[HIGH_LSB +: PIN_N];
  wire [PIN_N-1:0] want_low  = level_req[LOW_LSB +: PIN_N];
  wire [PIN_N-1:0] want_out  = dir_req[HIGH_LSB +: PIN_N];
  wire [PIN_N-1:0] want_in   = dir_req[LOW_LSB +: PIN_N];

  // both resolutions favour the safe state: a pin only fights a board driver
  // when software asked for output and never asked for input
  // low wins over high, input wins over output
  wire [PIN_N-1:0] drive_high = want_high & ~want_low;
  wire [PIN_N-1:0] is_output  = want_out & ~want_in;

  // an input pin is left undriven and its level bits ignored
  assign pin_oe  = is_output;
  assign pin_out = is_output & drive_high;

  // the gate uses the filtered level, so a driven pin 3 also blocks forwarding
  // forwarding is blocked by a high pin 3 only when the gate is enabled
  assign fwd_block = fwd_gate_en & pin_level[GATE_PIN];

  // registering the pin controls keeps decode glitches off the board
  // pin and gate outputs come from flops
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      general_pin_o    <= '0;
      general_pin_oe_o <= '0;
      forward_block_o  <= 1'h0;
    end else begin
      general_pin_o    <= pin_out;
      general_pin_oe_o <= pin_oe;
      forward_block_o  <= fwd_block;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  wire ar_fire = s_axi_arvalid_i & s_axi_arready_o;
  wire r_fire  = s_axi_rvalid_o & s_axi_rready_i;

  assign s_axi_arready_o = (rd_state == RD_IDLE);
  assign s_axi_rvalid_o  = (rd_state == RD_RESP);
  assign s_axi_rdata_o   = rdata;
  assign s_axi_rresp_o   = rresp;

  // reads decode the live address, which the master holds until it is taken
  // read address decode
  wire [ADDR_W-3:0] rd_word     = s_axi_araddr_i[ADDR_W-1:2];
  wire              rd_hit_chip = (rd_word == ADDR_CHIP_CTRL[ADDR_W-1:2]);
  wire              rd_hit_lvl  = (rd_word == ADDR_LEVEL[ADDR_W-1:2]);
  wire              rd_hit_dir  = (rd_word == ADDR_DIR[ADDR_W-1:2]);
  wire              rd_hit_smp  = (rd_word == ADDR_SAMPLE[ADDR_W-1:2]);
  wire              rd_mapped   = rd_hit_chip | rd_hit_lvl | rd_hit_dir | rd_hit_smp;

  // register views, high bits of each word read zero
  wire [7:0] chip_view   = 8'(fwd_gate_en) << FWD_GATE_BIT;
  wire [7:0] sample_view = {pin_level, SAMPLE_LO_VAL};

  // read mux
  wire [7:0] rd_byte = rd_hit_chip ? chip_view   :
                       rd_hit_lvl  ? level_req   :
                       rd_hit_dir  ? dir_req     :
                       rd_hit_smp  ? sample_view : 8'h00;

  // read state sequencing
  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      RD_IDLE: begin
        if (ar_fire) begin
          next_rd_state = RD_RESP;
        end
      end
      RD_RESP: begin
        if (r_fire) begin
          next_rd_state = RD_IDLE;
        end
      end
    endcase
  end

  // the answer is captured at the address handshake and then stands
  // unchanged until the master takes it, whatever the pins do meanwhile
  // read state and captured answer
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_state <= RD_IDLE;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      if (ar_fire) begin
        rdata <= {{(DATA_W-8){1'b0}}, rd_byte};
        rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule : fpgio_port
`default_nettype wire

// ==== verif/fpgio_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpgio_board_model
  import fpgio_pkg::*;
(
  input  wire logic [PIN_N-1:0] pin_out_i,
  input  wire logic [PIN_N-1:0] pin_oe_i,
  input  wire logic [PIN_N-1:0] board_level_i,
  output logic [PIN_N-1:0]      pin_level_o
);
  // a wire follows the device where it drives, else the board driver
  assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & board_level_i);
endmodule : fpgio_board_model
`default_nettype wire

// ==== verif/fpgio_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpgio_port_checker
  import fpgio_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              reset_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [DATA_W-1:0] s_axi_rdata_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              s_axi_rready_i,
  input wire logic [PIN_N-1:0]  general_pin_o,
  input wire logic [PIN_N-1:0]  general_pin_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  logic             rd_sample;
  logic [PIN_N-1:0] oe_dropped;

  // remember a pending sample read and pins that went back to input
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_sample  <= 1'b0;
      oe_dropped <= '0;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) rd_sample <= (s_axi_araddr_i == ADDR_SAMPLE);
      oe_dropped <= oe_dropped | ($past(general_pin_oe_o) & ~general_pin_oe_o);
    end
  end

  chk_undriven_low: assert property ((general_pin_o & ~general_pin_oe_o) == '0)
    else $error("pin level driven while not enabled");
  chk_input_stays: assert property ((oe_dropped & general_pin_oe_o) == '0)
    else $error("pin became output again after input request");
  chk_reset_input: assert property ($fell(reset_i) |-> general_pin_oe_o == '0)
    else $error("pin enabled right after reset");
  chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  chk_resp_blocks: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated after handshake");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  chk_read_blocks: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read response repeated after handshake");
  chk_sample_low: assert property (s_axi_rvalid_o && rd_sample |-> s_axi_rdata_o[3:0] == 4'h0)
    else $error("sample low nibble not zero");
  chk_pin_timing: assert property (!$past(reset_i) && $changed({general_pin_o, general_pin_oe_o})
    |-> $past(s_axi_bvalid_o))
    else $error("pin changed without a write");
endmodule : fpgio_port_checker

bind fpgio_port fpgio_port_checker u_checker (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .general_pin_o(general_pin_o),
  .general_pin_oe_o(general_pin_oe_o));
`default_nettype wire

// ==== verif/fpgio_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpgio_port_tb_top
  import fpgio_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              reset_i   = 1'b1;
  logic [ADDR_W-1:0] awaddr    = '0;
  logic [ADDR_W-1:0] araddr    = '0;
  logic [DATA_W-1:0] wdata     = '0;
  logic [STRB_W-1:0] wstrb     = '0;
  logic              awvalid   = 1'b0;
  logic              wvalid    = 1'b0;
  logic              bready    = 1'b0;
  logic              arvalid   = 1'b0;
  logic              rready    = 1'b0;
  logic [PIN_N-1:0]  ext_level = '0;
  logic              awready, wready, bvalid, arready, rvalid, fwd_block;
  logic [1:0]        bresp, rresp;
  logic [DATA_W-1:0] rdata;
  logic [PIN_N-1:0]  pin_out, pin_oe, pin_wire;
  int                errors    = 0;
  int                checks    = 0;

  // 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;

  fpgio_port dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .general_pin_i(pin_wire), .general_pin_o(pin_out),
    .general_pin_oe_o(pin_oe), .forward_block_o(fwd_block));

  fpgio_board_model u_board (
    .pin_out_i(pin_out), .pin_oe_i(pin_oe), .board_level_i(ext_level),
    .pin_level_o(pin_wire));

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // one write, both halves offered together
  task automatic axw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [STRB_W-1:0] s, input logic [1:0] er);
    logic       ta, tw, tb;
    logic [1:0] rb;
    @(posedge ref_clk_i);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge ref_clk_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bready && bvalid;
      rb = bresp;
      @(posedge ref_clk_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        check(DATA_W'(rb), DATA_W'(er));
        return;
      end
    end
    errors++;
    conclude();
  endtask : axw

  // one read, compared against expected data and response
  task automatic axr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ed,
                     input logic [1:0] er);
    logic              ta, tr;
    logic [DATA_W-1:0] rd;
    logic [1:0]        rr;
    @(posedge ref_clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge ref_clk_i);
      ta = arvalid && arready;
      tr = rready && rvalid;
      rd = rdata;
      rr = rresp;
      @(posedge ref_clk_i);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        check(rd, ed);
        check(DATA_W'(rr), DATA_W'(er));
        return;
      end
    end
    errors++;
    conclude();
  endtask : axr

  task automatic pins(input logic [PIN_N-1:0] eoe, input logic [PIN_N-1:0] eout);
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(DATA_W'(pin_oe), DATA_W'(eoe));
    check(DATA_W'(pin_out), DATA_W'(eout));
  endtask : pins

  task automatic board(input logic [PIN_N-1:0] lvl);
    @(posedge ref_clk_i);
    ext_level <= lvl;
    repeat (8) @(posedge ref_clk_i);
  endtask : board

  // values after reset and unmapped accesses
  task automatic t_reset();
    axr(ADDR_LEVEL, 32'h0, RESP_OKAY);
    axr(ADDR_DIR, 32'h0, RESP_OKAY);
    axr(ADDR_SAMPLE, 32'h0, RESP_OKAY);
    axw(12'h3F0, 32'hFF, 4'hF, RESP_SLVERR);
    axr(12'h3F0, 32'h0, RESP_SLVERR);
    pins(4'h0, 4'h0);
  endtask : t_reset

  // level and direction requests, precedence and stickiness
  task automatic t_drive();
    axw(ADDR_LEVEL, 32'h10, 4'hF, RESP_OKAY);
    pins(4'h0, 4'h0);
    axw(ADDR_DIR, 32'hF0, 4'hF, RESP_OKAY);
    pins(4'hF, 4'h1);
    axw(ADDR_LEVEL, 32'h20, 4'h0, RESP_OKAY);
    axw(ADDR_LEVEL, 32'h00, 4'hF, RESP_OKAY);
    axr(ADDR_LEVEL, 32'h10, RESP_OKAY);
    axw(ADDR_LEVEL, 32'h01, 4'hF, RESP_OKAY);
    pins(4'hF, 4'h0);
    axr(ADDR_LEVEL, 32'h11, RESP_OKAY);
    axw(ADDR_LEVEL, 32'hE0, 4'hF, RESP_OKAY);
    pins(4'hF, 4'hE);
    board(4'h0);
    axr(ADDR_SAMPLE, 32'hE0, RESP_OKAY);
    axw(ADDR_DIR, 32'h0F, 4'hF, RESP_OKAY);
    pins(4'h0, 4'h0);
    axr(ADDR_DIR, 32'hFF, RESP_OKAY);
    board(4'h5);
    axr(ADDR_SAMPLE, 32'h50, RESP_OKAY);
    axw(ADDR_SAMPLE, 32'hFF, 4'hF, RESP_OKAY);
    axr(ADDR_SAMPLE, 32'h50, RESP_OKAY);
  endtask : t_drive

  // forwarding gate follows pin 3 only while enabled
  task automatic t_gate();
    axw(ADDR_CHIP_CTRL, 32'hFF, 4'hF, RESP_OKAY);
    axr(ADDR_CHIP_CTRL, 32'h20, RESP_OKAY);
    board(4'hD);
    check(DATA_W'(fwd_block), 32'h1);
    board(4'h5);
    check(DATA_W'(fwd_block), 32'h0);
    axw(ADDR_CHIP_CTRL, 32'h00, 4'hF, RESP_OKAY);
    board(4'hD);
    check(DATA_W'(fwd_block), 32'h0);
  endtask : t_gate

  // resets in mid-run clear sticky requests, the second one while pins are driven
  task automatic t_rerst();
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    axr(ADDR_DIR, 32'h0, RESP_OKAY);
    axr(ADDR_LEVEL, 32'h0, RESP_OKAY);
    axw(ADDR_DIR, 32'h90, 4'hF, RESP_OKAY);
    axw(ADDR_LEVEL, 32'h80, 4'hF, RESP_OKAY);
    pins(4'h9, 4'h8);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    pins(4'h0, 4'h0);
    axr(ADDR_LEVEL, 32'h0, RESP_OKAY);
    axr(ADDR_DIR, 32'h0, RESP_OKAY);
  endtask : t_rerst

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_drive();
    t_gate();
    t_rerst();
    conclude();
  end
endmodule : fpgio_port_tb_top
`default_nettype wire
